// *** core/ivm_pkg.sv ***
package ivm_pkg;
    // ========================================
    // vector numbers, offsets, levels
    // ========================================
    localparam logic [7:0] VEC_ACCESS_ERR = 8'h02;
    localparam logic [7:0] VEC_CPU_LAST = 8'h3F;
    localparam logic [7:0] VEC_FRAME = 8'h5F;
    localparam logic [7:0] VEC_TWI = 8'h65;
    localparam logic [7:0] VEC_RSV_FIRST = 8'h73;
    localparam logic [7:0] VEC_RSV_LAST = 8'hFF;
    localparam logic [9:0] OFS_FRAME = 10'h17C;
    localparam logic [9:0] OFS_TWI = 10'h194;
    localparam logic [9:0] OFS_RSV_LAST = 10'h3FC;
    localparam logic [2:0] LVL_FRAME = 3'h2;
    localparam logic [2:0] PRI_FRAME = 3'h6;
    localparam logic [2:0] LVL_TWI = 3'h1;
    localparam logic [2:0] PRI_TWI = 3'h7;
    localparam int NSRC = 2;

    typedef struct packed {
        logic valid;
        logic [7:0] number;
        logic [9:0] offset;
        logic [2:0] level;
        logic [2:0] priority_in_level;
    } ivm_vec_t;

    typedef struct packed {
        logic byte_transfer_done;
        logic own_address_matched;
        logic arbitration_lost_flag;
        logic bus_timeout_flag;
    } ivm_twi_t;

    // table offset is four times the vector number
    function automatic logic [9:0] ivm_offset(input logic [7:0] num);
        ivm_offset = {num, 2'b00};
    endfunction : ivm_offset
endpackage : ivm_pkg

// *** core/ivm_pick.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivm_pick (
    // candidates
    input wire ivm_pkg::ivm_vec_t a,
    input wire ivm_pkg::ivm_vec_t b,
    // winner
    output ivm_pkg::ivm_vec_t win
);
    import ivm_pkg::*;
    always_comb begin
        if (!b.valid) begin
            win = a;
        end else if (!a.valid) begin
            win = b;
        end else if ({a.level, a.priority_in_level} >= {b.level, b.priority_in_level}) begin
            win = a;
        end else begin
            win = b;
        end
    end
endmodule : ivm_pick
`default_nettype wire

// *** core/ivm_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivm_top (
    // clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // frame source
    input wire logic FRAME_BEGIN_FLAG,
    input wire logic FRAME_BEGIN_IRQ_ENABLE,
    // two-wire source
    input wire ivm_pkg::ivm_twi_t TWI_FLAGS,
    input wire logic TWI_IRQ_ENABLE,
    // access check
    input wire logic ACCESS_VALID,
    input wire logic ACCESS_SUPERVISOR_ONLY,
    input wire logic CPU_USER_MODE,
    // to core
    output logic IRQ_REQ,
    output ivm_pkg::ivm_vec_t IRQ_VEC,
    output logic ACCESS_ERROR,
    output logic [9:0] ACCESS_ERROR_OFFSET,
    output logic SOFT_RESET
);
    import ivm_pkg::*;

    // ========================================
    // request vectors
    // ========================================
    ivm_vec_t cand [NSRC];
    ivm_vec_t best;
    logic [NSRC-1:0] pend;

    assign pend[0] = FRAME_BEGIN_FLAG & FRAME_BEGIN_IRQ_ENABLE;
    assign pend[1] = TWI_IRQ_ENABLE & (|TWI_FLAGS);

    // constant fields of each source
    // one function, though a new source also needs a pend term, a larger NSRC and a wider ivm_pick, which takes only two
    function automatic ivm_vec_t src_entry(input int idx, input logic req);
        ivm_vec_t entry;
        entry = '0;
        entry.valid = req;
        if (idx == 0) begin
            entry.number = VEC_FRAME;
            entry.level = LVL_FRAME;
            entry.priority_in_level = PRI_FRAME;
        end else begin
            entry.number = VEC_TWI;
            entry.level = LVL_TWI;
            entry.priority_in_level = PRI_TWI;
        end
        entry.offset = ivm_offset(entry.number);
        return entry;
    endfunction : src_entry

    for (genvar gi = 0; gi < NSRC; gi++) begin : g_src
        assign cand[gi] = src_entry(gi, pend[gi]);
    end

    ivm_pick ivm_pick_i (
        .a(cand[0]),
        .b(cand[1]),
        .win(best)
    );

    // ========================================
    // presentation window
    // ========================================
    // reserved vectors never presented
    // core range kept clear
    // a bad table entry is dropped rather than sent to a core handler
    function automatic logic presentable(input logic [7:0] num);
        presentable = (num > VEC_CPU_LAST) && (num < VEC_RSV_FIRST);
    endfunction : presentable

    logic show;
    assign show = best.valid & presentable(best.number);

    // ========================================
    // registered presentation
    // ========================================
    // reserved vectors never presented; ivm_pick may still pick one, which is then dropped
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_VEC <= '0;
            IRQ_REQ <= 1'b0;
        end else begin
            // outputs registered so the core sees a stable vector
            IRQ_VEC <= show ? best : '0;
            IRQ_REQ <= show;
        end
    end

    // ========================================
    // access error
    // ========================================
    logic viol;
    assign viol = ACCESS_VALID & ACCESS_SUPERVISOR_ONLY & CPU_USER_MODE;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ACCESS_ERROR <= 1'b0;
            ACCESS_ERROR_OFFSET <= '0;
        end else begin
            ACCESS_ERROR <= viol;
            ACCESS_ERROR_OFFSET <= viol ? ivm_offset(VEC_ACCESS_ERR) : '0;
        end
    end

    // handler soft reset
    // one pulse after the error, the handler is modelled in hardware here
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SOFT_RESET <= 1'b0;
        end else begin
            SOFT_RESET <= ACCESS_ERROR;
        end
    end

    // ========================================
    // request checks
    // ========================================
    // frame vector fields
    AST_FRAME_VEC: assert property (@(posedge MCLK) disable iff (!NRST)
        (pend[0] && !pend[1])
        |=> (IRQ_REQ && IRQ_VEC.number == 8'h5F && IRQ_VEC.offset == 10'h17C
        && IRQ_VEC.level == 3'h2 && IRQ_VEC.priority_in_level == 3'h6))
        else $error("frame vector wrong");
    AST_FRAME_GATE: assert property (@(posedge MCLK) disable iff (!NRST)
        (!FRAME_BEGIN_IRQ_ENABLE && !pend[1])
        |=> !IRQ_REQ)
        else $error("frame request leaked");
    AST_TWI_VEC: assert property (@(posedge MCLK) disable iff (!NRST)
        (pend[1] && !pend[0])
        |=> (IRQ_REQ && IRQ_VEC.number == 8'h65 && IRQ_VEC.offset == 10'h194
        && IRQ_VEC.level == 3'h1 && IRQ_VEC.priority_in_level == 3'h7))
        else $error("two-wire vector wrong");
    AST_TWI_GATE: assert property (@(posedge MCLK) disable iff (!NRST)
        (!TWI_IRQ_ENABLE && !pend[0])
        |=> !IRQ_REQ)
        else $error("two-wire request leaked");
    for (genvar ci = 0; ci < $bits(ivm_twi_t); ci++) begin : g_cause
        AST_TWI_CAUSE: assert property (@(posedge MCLK) disable iff (!NRST)
            (TWI_IRQ_ENABLE && TWI_FLAGS == (4'h1 << ci) && !pend[0])
            |=> (IRQ_REQ && IRQ_VEC.number == 8'h65))
            else $error("two-wire cause not routed");
    end
    AST_NO_RSV: assert property (@(posedge MCLK) disable iff (!NRST)
        IRQ_REQ
        |-> (IRQ_VEC.number < 8'h73))
        else $error("reserved vector presented");
    AST_NO_CPU: assert property (@(posedge MCLK) disable iff (!NRST)
        IRQ_REQ
        |-> (IRQ_VEC.number > 8'h3F))
        else $error("core vector presented");
    AST_IDLE: assert property (@(posedge MCLK) disable iff (!NRST)
        !(|pend)
        |=> (!IRQ_REQ && IRQ_VEC == '0))
        else $error("vector shown while idle");
    AST_ORDER: assert property (@(posedge MCLK) disable iff (!NRST)
        (pend[0] && pend[1])
        |=> (IRQ_VEC.number == 8'h5F))
        else $error("priority order wrong");
    AST_OFS: assert property (@(posedge MCLK) disable iff (!NRST)
        IRQ_REQ
        |-> (IRQ_VEC.offset == {IRQ_VEC.number, 2'b00}))
        else $error("offset not four times number");
    AST_TBL_OFS: assert property (@(posedge MCLK) disable iff (!NRST)
        cand[0].offset == 10'h17C && cand[1].offset == 10'h194)
        else $error("table offset wrong");
    AST_REQ_VALID: assert property (@(posedge MCLK) disable iff (!NRST)
        IRQ_REQ == IRQ_VEC.valid)
        else $error("request and vector disagree");

    // ========================================
    // access checks
    // ========================================
    // error then soft reset
    AST_ACC_ERR: assert property (@(posedge MCLK) disable iff (!NRST)
        viol
        |=> (ACCESS_ERROR && ACCESS_ERROR_OFFSET == 10'h008) ##1 SOFT_RESET)
        else $error("access error not handled");
    AST_NO_ERR: assert property (@(posedge MCLK) disable iff (!NRST)
        !$past(viol)
        |-> !ACCESS_ERROR)
        else $error("spurious access error");
    AST_ERR_SUPER: assert property (@(posedge MCLK) disable iff (!NRST)
        !(ACCESS_VALID && ACCESS_SUPERVISOR_ONLY && CPU_USER_MODE)
        |=> !ACCESS_ERROR)
        else $error("access error without violation");
    AST_ERR_OFS: assert property (@(posedge MCLK) disable iff (!NRST)
        !ACCESS_ERROR
        |-> (ACCESS_ERROR_OFFSET == 10'h000))
        else $error("error offset without error");
    AST_SRST_CAUSE: assert property (@(posedge MCLK) disable iff (!NRST)
        SOFT_RESET
        |-> $past(ACCESS_ERROR))
        else $error("soft reset without error");

    COV_FRAME: cover property (@(posedge MCLK) disable iff (!NRST) pend[0] ##1 IRQ_REQ);
    COV_TWI: cover property (@(posedge MCLK) disable iff (!NRST) pend[1] && !pend[0]);
    COV_BOTH: cover property (@(posedge MCLK) disable iff (!NRST) pend[0] && pend[1]);
    COV_RST: cover property (@(posedge MCLK) disable iff (!NRST) viol ##2 SOFT_RESET);
    COV_SUPER: cover property (@(posedge MCLK) disable iff (!NRST)
        ACCESS_VALID && ACCESS_SUPERVISOR_ONLY && !CPU_USER_MODE);
endmodule : ivm_top
`default_nettype wire

// *** bench/ivm_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model (
    // core side
    input wire logic clk,
    input wire logic nrst,
    input wire logic soft_reset,
    output logic [3:0] resets
);
    // ========================================
    // soft resets taken by the error handler
    // counts each cycle that soft_reset is high; nothing in the device is reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resets <= 4'h0;
        end else if (soft_reset) begin
            resets <= resets + 4'h1;
        end
    end
endmodule : ivm_core_model
`default_nettype wire

// *** bench/ivm_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module ivm_top_test;
    import ivm_pkg::*;
    logic mclk = 0, nrst = 0, fb = 0, fe = 0, te = 0, av = 0, so = 0, um = 0;
    logic irq, aerr, srst;
    logic [9:0] aofs;
    logic [3:0] resets;
    ivm_twi_t tf = '0;
    ivm_vec_t vec;
    int err_count = 0, checks = 0;
    localparam ivm_vec_t FRM = '{1'b1, 8'h5F, 10'h17C, 3'h2, 3'h6};
    localparam ivm_vec_t TWI = '{1'b1, 8'h65, 10'h194, 3'h1, 3'h7};
    always #12.5 mclk = ~mclk;
    ivm_top ivm_top_i (.MCLK(mclk), .NRST(nrst), .FRAME_BEGIN_FLAG(fb), .FRAME_BEGIN_IRQ_ENABLE(fe),
        .TWI_FLAGS(tf), .TWI_IRQ_ENABLE(te), .ACCESS_VALID(av), .ACCESS_SUPERVISOR_ONLY(so),
        .CPU_USER_MODE(um), .IRQ_REQ(irq), .IRQ_VEC(vec), .ACCESS_ERROR(aerr),
        .ACCESS_ERROR_OFFSET(aofs), .SOFT_RESET(srst));
    ivm_core_model ivm_core_model_i (.clk(mclk), .nrst(nrst), .soft_reset(srst), .resets(resets));
    // ========================================
    // helpers
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task step;
        @(posedge mclk);
        #1;
    endtask : step
    // ========================================
    // scenarios
    task frame_case;
        fb = 1;
        step;
        chk({irq, vec}, 0);
        fe = 1;
        step;
        chk({irq, vec}, {1'b1, FRM});
        fb = 0;
        step;
        chk({irq, vec}, 0);
        fe = 0;
    endtask : frame_case
    task twi_case;
        te = 1;
        for (int i = 0; i < 4; i++) begin
            tf = 4'h1 << i;
            step;
            chk({irq, vec}, {1'b1, TWI});
        end
        te = 0;
        step;
        chk({irq, vec}, 0);
        tf = '0;
        step;
    endtask : twi_case
    task prio_case;
        fb = 1;
        fe = 1;
        te = 1;
        tf = 4'hF;
        step;
        chk(vec, FRM);
        fe = 0;
        step;
        chk(vec, TWI);
        fb = 0;
        te = 0;
        tf = '0;
    endtask : prio_case
    task access_case;
        av = 1;
        so = 1;
        um = 1;
        step;
        chk({aerr, aofs}, {1'b1, 10'h008});
        av = 0;
        step;
        chk({aerr, srst, aofs}, {2'b01, 10'h000});
        um = 0;
        av = 1;
        step;
        chk({aerr, resets}, {1'b0, 4'h1});
        av = 0;
        step;
        chk(srst, 0);
        so = 0;
        um = 1;
        av = 1;
        step;
        chk({aerr, aofs}, 0);
        av = 0;
        um = 0;
    endtask : access_case
    task reset_case;
        step;
        fb = 1;
        fe = 1;
        av = 1;
        so = 1;
        um = 1;
        step;
        chk({irq, aerr}, 2'b11);
        nrst = 0;
        #1;
        chk({irq, vec}, 0);
        chk({aerr, aofs, srst}, 0);
        step;
        nrst = 1;
        step;
        chk({irq, vec}, {1'b1, FRM});
        chk({aerr, aofs, srst}, {1'b1, 10'h008, 1'b0});
        fb = 0;
        fe = 0;
        av = 0;
        um = 0;
        step;
        chk({irq, aerr, srst}, 3'b001);
        step;
        chk({srst, resets}, {1'b0, 4'h1});
    endtask : reset_case
    task results;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        repeat (4) @(posedge mclk);
        #1 nrst = 1;
        frame_case;
        twi_case;
        prio_case;
        access_case;
        reset_case;
        results;
    end
endmodule : ivm_top_test
`default_nettype wire
